// ==== design/led_display_write_port.sv ====
// Parallel write port, control word and multiplexed LED scan
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Select high writes the control word; select low writes display memory.
// - Data and select are taken on the rising edge of the write strobe.
// - Memory write: data bits 0..3 are display bits (all 8 in raw mode); bit 7 is the point.
// - Control bit 4 high runs the display; low stops and blanks it.
// - Control bit 5 high shows raw memory bits; low decodes characters.
// - Control bit 6 high picks hexadecimal; low picks the alternate set.
// - Control bit 7 high announces a sequential eight-digit burst.
// - With bit 7 low, bits 0..2 address the digit for single update.
// - Control bit 3 picks bank A (high) or B (low) in decode modes.
// - Eight digit outputs and eight segment outputs multiplex the memory.
// - Each digit is scanned at 390 Hz.
// - All digits blank at least 2 us between activations; never overlap.
module led_display_write_port #(
  parameter int SLOT_CYCLES  = led_display_pkg::SLOT_CYCLES,
  parameter int BLANK_CYCLES = led_display_pkg::BLANK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] data_in_i,
  input  wire logic       select_i,
  input  wire logic       write_strobe_i,
  output logic      [7:0] digit_o,
  output logic      [7:0] seg_o
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [7:0] data_s1_q, data_s2_q, data_s3_q;
  logic       sel_s1_q, sel_s2_q, sel_s3_q;
  logic       strb_s1_q, strb_s2_q, strb_s3_q;
  logic       wr_edge;
  logic [7:0] wr_data;
  logic       wr_sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
      data_s3_q <= 8'h00;
      sel_s1_q  <= 1'b0;
      sel_s2_q  <= 1'b0;
      sel_s3_q  <= 1'b0;
      // Strobe idles high; starting low would fake a write after reset
      strb_s1_q <= 1'b1;
      strb_s2_q <= 1'b1;
      strb_s3_q <= 1'b1;
    end else begin
      data_s1_q <= data_in_i;
      data_s2_q <= data_s1_q;
      data_s3_q <= data_s2_q;
      sel_s1_q  <= select_i;
      sel_s2_q  <= sel_s1_q;
      sel_s3_q  <= sel_s2_q;
      strb_s1_q <= write_strobe_i;
      strb_s2_q <= strb_s1_q;
      strb_s3_q <= strb_s2_q;
    end
  end

  // Data may change right after the strobe rises (zero hold), so the
  // values taken are those seen one cycle before the edge showed up.
  assign wr_edge = strb_s2_q & ~strb_s3_q;
  assign wr_data = data_s3_q;
  assign wr_sel  = sel_s3_q;

  // ------------------------------------------------------------------
  // Control word and write pointer
  // ------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [2:0] ptr_q;
  logic       seq_q;
  logic [3:0] left_q;
  logic [7:0] point_q;
  logic       ctrl_wr;
  logic       mem_wr;
  logic       raw_mode;
  logic       bank_a;
  logic [led_display_pkg::MEM_AW-1:0] wr_addr;
  logic [7:0] mem_wr_data;

  assign ctrl_wr  = wr_edge & wr_sel;
  // A finished burst ignores further data until the next control word
  assign mem_wr   = wr_edge & ~wr_sel & (~seq_q | (left_q != 4'h0));
  assign raw_mode = ctrl_q[led_display_pkg::RAW_BIT];
  assign bank_a   = ctrl_q[led_display_pkg::BANK_BIT] | raw_mode;
  assign wr_addr  = {bank_a, ptr_q};
  assign mem_wr_data = raw_mode ? wr_data : {4'h0, wr_data[3:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= led_display_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q  <= 3'h0;
      seq_q  <= 1'b0;
      left_q <= 4'h0;
    end else if (ctrl_wr) begin
      if (wr_data[led_display_pkg::BURST_BIT]) begin
        ptr_q  <= 3'h0;
        seq_q  <= 1'b1;
        left_q <= led_display_pkg::BURST_LEN;
      end else begin
        ptr_q  <= wr_data[led_display_pkg::ADDR_LSB +:
                          led_display_pkg::ADDR_W];
        seq_q  <= 1'b0;
        left_q <= 4'h0;
      end
    end else if (mem_wr && seq_q) begin
      ptr_q  <= ptr_q + 3'h1;
      left_q <= left_q - 4'h1;
    end
  end

  // Point is kept apart from the banks so it shows for either bank
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      point_q <= 8'h00;
    end else if (mem_wr && !raw_mode) begin
      point_q[ptr_q] <= wr_data[led_display_pkg::POINT_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Scan timing
  // ------------------------------------------------------------------
  led_display_pkg::scan_state_type state_q;
  logic [led_display_pkg::CNT_W-1:0] cnt_q;
  logic [2:0] idx_q;
  logic       slot_tick;
  logic       running;
  logic [led_display_pkg::MEM_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] seg_d;

  assign running   = ctrl_q[led_display_pkg::RUN_BIT];
  assign slot_tick = (cnt_q ==
    led_display_pkg::CNT_W'(SLOT_CYCLES - 1));
  assign rd_addr   = {bank_a, idx_q};

  always_ff @(posedge clk_i) begin
    if (rst_i || !running || slot_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= 3'h0;
    end else if (slot_tick) begin
      idx_q <= idx_q + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= led_display_pkg::ST_OFF;
    end else if (!running) begin
      state_q <= led_display_pkg::ST_OFF;
    end else begin
      case (state_q)
        led_display_pkg::ST_OFF: begin
          state_q <= led_display_pkg::ST_BLANK;
        end
        led_display_pkg::ST_BLANK: begin
          if (cnt_q == led_display_pkg::CNT_W'(BLANK_CYCLES - 1)) begin
            state_q <= led_display_pkg::ST_LIT;
          end
        end
        led_display_pkg::ST_LIT: begin
          if (slot_tick) begin
            state_q <= led_display_pkg::ST_BLANK;
          end
        end
        default: begin
          state_q <= led_display_pkg::ST_OFF;
        end
      endcase
    end
  end

  display_memory #(
    .WIDTH (8),
    .DEPTH (led_display_pkg::MEM_DEPTH),
    .AW    (led_display_pkg::MEM_AW)
  ) u_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (mem_wr),
    .wr_addr_i (wr_addr),
    .wr_data_i (mem_wr_data),
    .rd_addr_i (rd_addr),
    .rd_data_o (rd_data)
  );

  always_comb begin
    if (raw_mode) begin
      seg_d = rd_data;
    end else if (ctrl_q[led_display_pkg::HEX_BIT]) begin
      seg_d = {point_q[idx_q], led_display_pkg::hex_segments(rd_data[3:0])};
    end else begin
      seg_d = {point_q[idx_q], led_display_pkg::alt_segments(rd_data[3:0])};
    end
  end

  // Outputs follow the state one cycle late; the read is settled long
  // before the blanking gap ends, so no stale digit ever lights.
  always_ff @(posedge clk_i) begin
    if (rst_i || !running || state_q != led_display_pkg::ST_LIT) begin
      digit_o <= 8'h00;
      seg_o   <= 8'h00;
    end else begin
      digit_o <= 8'h01 << idx_q;
      seg_o   <= seg_d;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence ctrl_write_s;
    wr_edge && wr_sel;
  endsequence

  sequence data_write_s;
    wr_edge && !wr_sel;
  endsequence

  AST_CTRL_LOAD: assert property (
    ctrl_write_s |=> ctrl_q == $past(wr_data))
    else $error("control word not loaded");
  AST_MEM_KEEPS_CTRL: assert property (
    data_write_s |=> $stable(ctrl_q))
    else $error("memory write changed control word");
  AST_SINGLE_ADDR: assert property (
    ctrl_write_s ##0 !wr_data[7] |=> ptr_q == $past(wr_data[2:0]))
    else $error("single digit address wrong");
  AST_BURST_START: assert property (
    ctrl_write_s ##0 wr_data[7] |=> ptr_q == 3'h0 && left_q == 4'h8)
    else $error("burst did not start at digit zero");
  AST_POINT_STORE: assert property (
    mem_wr && !raw_mode |=> point_q[$past(ptr_q)] == $past(wr_data[7]))
    else $error("point bit not stored");
  AST_SHUTDOWN_DARK: assert property (
    !running |=> digit_o == 8'h00 && seg_o == 8'h00)
    else $error("outputs lit in shutdown");
  AST_ONE_DIGIT: assert property (
    $onehot0(digit_o))
    else $error("digit drives overlap");
  AST_BLANK_GAP: assert property (
    $fell(|digit_o) |-> (digit_o == 8'h00) [*8])
    else $error("blanking gap too short");
  AST_NEXT_DIGIT: assert property (
    $rose(|digit_o) ##1 (digit_o != 8'h00) [*2] |-> $stable(digit_o))
    else $error("digit changed while lit");

endmodule
`default_nettype wire

// ==== design/led_display_pkg.sv ====
// Constants, types and decode tables for the LED display write port
`default_nettype none
package led_display_pkg;

  // ------------------------------------------------------------------
  // Clock and display timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int DIGITS        = 8;
  localparam int SCAN_HZ       = 390;
  // Longest slot that still gives the scan rate: rounds down
  localparam int SLOT_CYCLES   = CLK_HZ / (SCAN_HZ * DIGITS);
  localparam int BLANK_NS      = 10_000;
  localparam int BLANK_MIN_NS  = 2_000;
  // Least times: round up to whole cycles
  localparam int BLANK_CYCLES  =
    (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_MIN_CYCLES =
    (BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;

  // ------------------------------------------------------------------
  // Control word layout
  // ------------------------------------------------------------------
  localparam int          ADDR_LSB   = 0;
  localparam int          ADDR_W     = 3;
  localparam int          BANK_BIT   = 3;
  localparam int          RUN_BIT    = 4;
  localparam int          RAW_BIT    = 5;
  localparam int          HEX_BIT    = 6;
  localparam int          BURST_BIT  = 7;
  localparam int          POINT_BIT  = 7;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [3:0]  BURST_LEN  = 4'h8;
  localparam int          MEM_DEPTH  = 16;
  localparam int          MEM_AW     = 4;

  // ------------------------------------------------------------------
  // Scan states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_BLANK = 2'b01,
    ST_LIT   = 2'b11
  } scan_state_type;

  // Segments packed {g,f,e,d,c,b,a}
  function automatic logic [6:0] hex_segments(input logic [3:0] v);
    case (v)
      4'h0: hex_segments = 7'h3F;
      4'h1: hex_segments = 7'h06;
      4'h2: hex_segments = 7'h5B;
      4'h3: hex_segments = 7'h4F;
      4'h4: hex_segments = 7'h66;
      4'h5: hex_segments = 7'h6D;
      4'h6: hex_segments = 7'h7D;
      4'h7: hex_segments = 7'h07;
      4'h8: hex_segments = 7'h7F;
      4'h9: hex_segments = 7'h6F;
      4'hA: hex_segments = 7'h77;
      4'hB: hex_segments = 7'h7C;
      4'hC: hex_segments = 7'h39;
      4'hD: hex_segments = 7'h5E;
      4'hE: hex_segments = 7'h79;
      default: hex_segments = 7'h71;
    endcase
  endfunction

  // Alternate set: digits, dash, E, H, L, P, blank
  function automatic logic [6:0] alt_segments(input logic [3:0] v);
    case (v)
      4'hA: alt_segments = 7'h40;
      4'hB: alt_segments = 7'h79;
      4'hC: alt_segments = 7'h76;
      4'hD: alt_segments = 7'h38;
      4'hE: alt_segments = 7'h73;
      4'hF: alt_segments = 7'h00;
      default: alt_segments = hex_segments(v);
    endcase
  endfunction

endpackage
`default_nettype wire

// ==== design/display_memory.sv ====
// Two-port display memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module display_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Contents are not cleared; an unwritten location scans out whatever the memory holds
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule
`default_nettype wire

// ==== testbench/host_writer.sv ====
// Microprocessor-side model that writes the display port
`timescale 1ns/1ps
`default_nettype none
module host_writer (
  input  wire logic       clk_i,
  output var  logic [7:0] data_o,
  output var  logic       sel_o,
  output var  logic       strobe_o
);
  initial begin
    data_o   = 8'h00;
    sel_o    = 1'b0;
    strobe_o = 1'b1;
  end
  // One write: strobe low with data set up, rising edge latches it,
  // then a long high recovery before the next write may start
  task automatic write(input logic s, input logic [7:0] d);
    @(posedge clk_i) #1;
    data_o   = d;
    sel_o    = s;
    strobe_o = 1'b0;
    // Seven cycles give more than the setup the port needs
    repeat (7) @(posedge clk_i);
    #1 strobe_o = 1'b1;
    @(posedge clk_i) #1;
    // Bus moves on after the edge, so stale data cannot help the design
    data_o = ~d;
    sel_o  = ~s;
    repeat (22) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the LED display write port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SLOT  = 64;
  localparam int BLANK = 10;
  localparam logic [6:0] HEX_T [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
    7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79,
    7'h71};
  localparam logic [6:0] ALT_T [6] = '{7'h40, 7'h79, 7'h76, 7'h38, 7'h73,
    7'h00};
  localparam logic [7:0] CT [8] = '{8'hB0, 8'hD8, 8'hD0, 8'h58, 8'h18,
    8'h1D, 8'h08, 8'h18};
  localparam int NW [8] = '{9, 8, 8, 0, 0, 2, 1, 0};
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  data_w;
  logic [7:0]  digit_w;
  logic [7:0]  seg_w;
  logic        sel_w;
  logic        strobe_w;
  logic        chk_on;
  logic        lit_ok;
  logic [7:0]  ctrl;
  logic [7:0]  last_dig;
  logic [7:0]  raw_a [8];
  logic [3:0]  nib_a [8];
  logic [3:0]  nib_b [8];
  logic        pt [8];
  logic [31:0] rnd;
  int          failures;
  int          n_checks;
  int          cycles;
  int          gap;
  int          since;
  int          ptr;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  led_display_write_port #(.SLOT_CYCLES(SLOT), .BLANK_CYCLES(BLANK)) uut (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .data_in_i      (data_w),
    .select_i       (sel_w),
    .write_strobe_i (strobe_w),
    .digit_o        (digit_w),
    .seg_o          (seg_w)
  );

  host_writer hw (
    .clk_i    (clk_i),
    .data_o   (data_w),
    .sel_o    (sel_w),
    .strobe_o (strobe_w)
  );

  // ------------------------------------------------------------------
  // Reference model and helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] rnd8();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction

  function automatic logic [7:0] exp_seg(input int i);
    logic [3:0] n;
    n = ctrl[3] ? nib_a[i] : nib_b[i];
    if (ctrl[5]) return raw_a[i];
    return {pt[i], (ctrl[6] || n < 4'hA) ? HEX_T[n] : ALT_T[n - 4'hA]};
  endfunction

  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic put(input logic s, input logic [7:0] d);
    int i;
    i = ctrl[7] ? ptr : int'(ctrl[2:0]);
    if (s) begin
      ctrl = d;
      ptr  = 0;
    end else if (!ctrl[7] || ptr < 8) begin
      if (ctrl[5]) raw_a[i] = d;
      else if (ctrl[3]) nib_a[i] = d[3:0];
      else nib_b[i] = d[3:0];
      if (!ctrl[5]) pt[i] = d[7];
      ptr++;
    end
    hw.write(s, d);
  endtask

  // Checking is off while writes land, since a slot may latch either side
  task automatic phase(input logic [7:0] c, input int n);
    chk_on = 1'b0;
    put(1'b1, c);
    repeat (n) put(1'b0, rnd8());
    repeat (80) @(posedge clk_i);
    chk_on = 1'b1;
    repeat (8 * SLOT + 80) @(posedge clk_i);
  endtask

  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scan monitor
  // ------------------------------------------------------------------
  always @(negedge clk_i) begin
    cycles++;
    since++;
    if (chk_on && !ctrl[4]) begin
      cmp8("dark digits", 8'h00, digit_w);
      cmp8("dark segments", 8'h00, seg_w);
    end
    if (digit_w !== 8'h00 && gap > 0) begin
      if (chk_on && ctrl[4]) begin
        cmp8("one hot", 8'h01, {7'h00, $onehot(digit_w)});
        cmp8("segments", exp_seg($clog2(digit_w)), seg_w);
        if (lit_ok) begin
          cmp8("order", {last_dig[6:0], last_dig[7]}, digit_w);
          cmp8("blank gap", 8'h01, {7'h00, gap >= BLANK});
          cmp8("slot", 8'(SLOT), 8'(since));
        end
      end
      lit_ok   = chk_on;
      last_dig = digit_w;
      since    = 0;
      gap      = 0;
    end
    if (digit_w === 8'h00) gap++;
    if (!chk_on) lit_ok = 1'b0;
    if (cycles > 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    rst_i    = 1'b1;
    rnd      = 32'h0001_6851;
    ctrl     = 8'h00;
    last_dig = 8'h00;
    chk_on   = 1'b0;
    lit_ok   = 1'b0;
    failures = 0;
    n_checks = 0;
    cycles   = 0;
    gap      = 0;
    since    = 0;
    ptr      = 0;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk_on = 1'b1;
    repeat (200) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      phase(CT[k], NW[k]);
    end
    results();
  end
endmodule
`default_nettype wire
